// file: rtl/sas_params.svh
// constants for the stack address arithmetic slice
`ifndef SAS_PARAMS_SVH
`define SAS_PARAMS_SVH
`define SAS_WIDTH 4
`define SAS_REG_RESET 4'h0
`define SAS_OP_LOW_BIT 0
`endif

// file: rtl/sas_pkg.sv
// types shared by the stack address arithmetic slice
`include "sas_params.svh"
package sas_pkg;
   typedef logic [`SAS_WIDTH-1:0] sas_nib_t;
   // operand selection for the adder
   typedef enum logic [1:0]
   {
      SAS_SRC_NONE = 2'b00,
      SAS_SRC_FIRST = 2'b01,
      SAS_SRC_SECOND = 2'b10,
      SAS_SRC_THIRD = 2'b11
   } sas_src_e;
   // decoded instruction
   typedef struct packed
   {
      sas_src_e operand;
      sas_src_e dest;
      sas_src_e showReg;
   } sas_dec_s;
   // registered state except the carry out
   typedef struct packed
   {
      sas_nib_t firstAddrReg;
      sas_nib_t secondAddrReg;
      sas_nib_t thirdAddrReg;
      sas_nib_t resultReg;
      sas_nib_t addrBusOut;
      logic addrOe;
      logic resultOe;
      sas_nib_t resultBusN;
   } sas_state_s;
endpackage : sas_pkg

// file: rtl/sas_decode.sv
// instruction decoder for the stack address arithmetic slice
`timescale 1ns/1ns
module sas_decode
(
   input wire logic [3:0] opSel,
   output sas_pkg::sas_dec_s dec
);
   import sas_pkg::*;

   // ----------------------------------------
   // decode of all sixteen codes
   // ----------------------------------------
   always_comb
   begin
      dec = '{SAS_SRC_NONE, SAS_SRC_NONE, SAS_SRC_NONE};
      case (opSel) // RULE_02
         4'h0, 4'h1: dec = '{SAS_SRC_FIRST, SAS_SRC_FIRST, SAS_SRC_FIRST}; // RULE_10
         4'h2, 4'h3: dec = '{SAS_SRC_FIRST, SAS_SRC_SECOND, SAS_SRC_FIRST}; // RULE_10
         4'h4, 4'h5: dec = '{SAS_SRC_FIRST, SAS_SRC_THIRD, SAS_SRC_FIRST}; // RULE_10
         4'h6, 4'h7: dec = '{SAS_SRC_SECOND, SAS_SRC_SECOND, SAS_SRC_SECOND}; // RULE_10
         4'h8, 4'h9: dec = '{SAS_SRC_NONE, SAS_SRC_THIRD, SAS_SRC_THIRD}; // RULE_11 RULE_03
         4'ha: dec = '{SAS_SRC_NONE, SAS_SRC_NONE, SAS_SRC_FIRST}; // RULE_12
         4'hb: dec = '{SAS_SRC_NONE, SAS_SRC_FIRST, SAS_SRC_FIRST}; // RULE_11
         4'hc: dec = '{SAS_SRC_THIRD, SAS_SRC_NONE, SAS_SRC_THIRD}; // RULE_12
         4'hd: dec = '{SAS_SRC_THIRD, SAS_SRC_THIRD, SAS_SRC_THIRD}; // RULE_11
         4'he: dec = '{SAS_SRC_NONE, SAS_SRC_NONE, SAS_SRC_SECOND}; // RULE_12
         4'hf: dec = '{SAS_SRC_NONE, SAS_SRC_SECOND, SAS_SRC_SECOND}; // RULE_11
         default: dec = '{SAS_SRC_NONE, SAS_SRC_NONE, SAS_SRC_NONE};
      endcase
   end
endmodule : sas_decode

// file: rtl/sas_slice.sv
// top of the stack address arithmetic slice
`timescale 1ns/1ns
// Contract
// [RULE_01] three 4-bit address registers, each loadable from the adder sum
// [RULE_02] all sixteen op_sel codes decode to distinct operations
// [RULE_03] upper op_sel bits pick the register operand, or none for offset plus carry
// [RULE_04] the inverted offset bus is always one adder operand, with carry
// [RULE_05] next edge writes sum to one register and result register when gated
// [RULE_06] step gate high blocks all register updates; controller holds it low
// [RULE_07] a microcycle starts on the rising edge, result caught next edge
// [RULE_08] low op_sel bit high puts the adder sum on the address bus
// [RULE_09] low op_sel bit low puts the selected register on the address bus
// [RULE_10] codes 0 to 7 use first or second register with stated destinations
// [RULE_11] codes 8 to f load third, first, second or add to third when odd
// [RULE_12] even codes a, c, e change no register, only drive the address bus
// [RULE_13] every increment, decrement or transfer completes in one clock
// [RULE_14] active-low carries ripple from slice to slice; carry out is registered here, so it follows its inputs by one clock
// [RULE_15] the result register drives the inverted result bus via three-state
// [RULE_16] address bus driven only while its enable is low
// [RULE_17] result bus driven only while its enable is low
// [RULE_18] controller fetches with operand one on the first register keep code
// [RULE_19] controller may add a displacement to first register into third next cycle
// [RULE_20] offset and carries are inverted at the adder so registers hold true values
module sas_slice
(
   input wire logic mclk,
   input wire logic rstn,
   input wire logic [3:0] opSel,
   input wire sas_pkg::sas_nib_t offsetInN,
   input wire logic carryInN,
   input wire logic stepGateN,
   input wire logic addrDriveEnN,
   input wire logic resultDriveEnN,
   output sas_pkg::sas_nib_t addrBusOut,
   output logic addrBusOe,
   output sas_pkg::sas_nib_t resultBusN,
   output logic resultBusOe,
   output logic carryOutN
);
   import sas_pkg::*;

   sas_state_s st;
   sas_state_s next_st;
   sas_dec_s dec;
   sas_nib_t operandReg;
   sas_nib_t sum;
   logic carryOut;
   logic carryOutReg;
   logic next_carryOut;

   // ----------------------------------------
   // decode
   // ----------------------------------------
   sas_decode sas_decode_inst
   (
      .opSel(opSel),
      .dec(dec)
   );

   // ----------------------------------------
   // adder
   // ----------------------------------------
   // register operand chosen by upper instruction bits
   always_comb
   begin
      case (dec.operand) // RULE_03
         SAS_SRC_FIRST: operandReg = st.firstAddrReg;
         SAS_SRC_SECOND: operandReg = st.secondAddrReg;
         SAS_SRC_THIRD: operandReg = st.thirdAddrReg;
         default: operandReg = `SAS_REG_RESET;
      endcase
   end

   // inputs arrive inverted; registers keep true form so chained slices agree
   assign {carryOut, sum} = {1'b0, operandReg} + {1'b0, ~offsetInN}
      + {4'h0, ~carryInN}; // RULE_04 RULE_20 RULE_14

   // ----------------------------------------
   // next state
   // ----------------------------------------
   // outputs are registered, so the address bus follows its cause by one clock
   always_comb
   begin
      next_st = st;
      next_carryOut = carryOut;
      if (!stepGateN) // RULE_06 RULE_05
      begin
         if (dec.dest != SAS_SRC_NONE) // RULE_12
         begin
            next_st.resultReg = sum; // RULE_05 RULE_13
            case (dec.dest) // RULE_01
               SAS_SRC_FIRST: next_st.firstAddrReg = sum;
               SAS_SRC_SECOND: next_st.secondAddrReg = sum;
               SAS_SRC_THIRD: next_st.thirdAddrReg = sum;
               default: next_st.resultReg = sum;
            endcase
         end
      end
      // address bus mux, independent of the step gate
      if (opSel[`SAS_OP_LOW_BIT]) // RULE_08
         next_st.addrBusOut = sum;
      else
      begin
         case (dec.showReg) // RULE_09
            SAS_SRC_FIRST: next_st.addrBusOut = st.firstAddrReg;
            SAS_SRC_SECOND: next_st.addrBusOut = st.secondAddrReg;
            SAS_SRC_THIRD: next_st.addrBusOut = st.thirdAddrReg;
            default: next_st.addrBusOut = `SAS_REG_RESET;
         endcase
      end
      next_st.addrOe = addrDriveEnN; // RULE_16
      next_st.resultOe = resultDriveEnN; // RULE_17
      next_st.resultBusN = ~next_st.resultReg; // RULE_15
   end

   // ----------------------------------------
   // state register
   // ----------------------------------------
   // reset is not part of the slice proper; added so state is defined
   always_ff @(posedge mclk)
   begin
      if (!rstn)
      begin
         st <= '{`SAS_REG_RESET, `SAS_REG_RESET, `SAS_REG_RESET, `SAS_REG_RESET,
                 `SAS_REG_RESET, 1'b1, 1'b1, 4'hf};
         carryOutReg <= 1'b0;
      end
      else
      begin
         st <= next_st; // RULE_07
         carryOutReg <= next_carryOut;
      end
   end

   assign addrBusOut = st.addrBusOut;
   assign addrBusOe = st.addrOe;
   assign resultBusN = st.resultBusN;
   assign resultBusOe = st.resultOe;
   assign carryOutN = ~carryOutReg; // RULE_14

   // ----------------------------------------
   // checks
   // ----------------------------------------
   sequence seqGatedWrite;
      !stepGateN && dec.dest != SAS_SRC_NONE;
   endsequence

   AST_RESULT_LOAD: assert property (@(posedge mclk) disable iff (!rstn) // RULE_05
      seqGatedWrite |=> st.resultReg == $past(sum))
      else $error("result register missed the sum");
   AST_GATE_HOLD: assert property (@(posedge mclk) disable iff (!rstn) // RULE_06
      stepGateN |=> $stable(st.firstAddrReg) && $stable(st.secondAddrReg)
         && $stable(st.thirdAddrReg) && $stable(st.resultReg))
      else $error("register changed while gate high");
   AST_BLANK_CODES: assert property (@(posedge mclk) disable iff (!rstn) // RULE_12
      (opSel == 4'ha || opSel == 4'hc || opSel == 4'he) |=> $stable(st.resultReg))
      else $error("blank code changed result register");
   AST_SUM_ON_BUS: assert property (@(posedge mclk) disable iff (!rstn) // RULE_08
      opSel[0] |=> addrBusOut == $past(sum))
      else $error("address bus is not the sum");
   AST_FIRST_KEEP: assert property (@(posedge mclk) disable iff (!rstn) // RULE_09
      opSel == 4'h0 |=> addrBusOut == $past(st.firstAddrReg))
      else $error("address bus is not first register");
   AST_FIRST_INC: assert property (@(posedge mclk) disable iff (!rstn) // RULE_10
      (opSel[3:1] == 3'b000 && !stepGateN) |=> st.firstAddrReg == $past(sum))
      else $error("first register not written");
   AST_THIRD_LOAD: assert property (@(posedge mclk) disable iff (!rstn) // RULE_11
      (opSel == 4'h9 && !stepGateN) |=> st.thirdAddrReg == $past(~offsetInN + {3'h0, ~carryInN}))
      else $error("third register not loaded with offset");
   AST_ADDR_OE: assert property (@(posedge mclk) disable iff (!rstn) // RULE_16
      addrDriveEnN |=> addrBusOe)
      else $error("address bus driven while disabled");
   AST_RES_OE: assert property (@(posedge mclk) disable iff (!rstn) // RULE_17
      resultDriveEnN |=> resultBusOe)
      else $error("result bus driven while disabled");
   AST_RES_INV: assert property (@(posedge mclk) disable iff (!rstn) // RULE_15
      ##1 resultBusN == ~st.resultReg)
      else $error("result bus not inverted result register");
endmodule : sas_slice

// file: dv/sas_seq.sv
// sequencer model that drives instruction, operand, carry and execute
`timescale 1ns/1ns
module sas_seq
(
   input wire logic mclk,
   output logic [3:0] opSel,
   output sas_pkg::sas_nib_t offsetInN,
   output logic carryInN,
   output logic stepGateN
);
   import sas_pkg::*;
   // idle with the gate shut so nothing is written before the first step
   initial
   begin
      opSel = 4'h0;
      offsetInN = 4'hf;
      carryInN = 1'b1;
      stepGateN = 1'b1;
   end
   // change off the sampling edge; true values leave inverted
   task automatic issue(input logic [3:0] c, input sas_nib_t d, input logic ci, input logic g);
      @(negedge mclk);
      opSel = c;
      offsetInN = ~d;
      carryInN = ~ci;
      stepGateN = g;
   endtask : issue
endmodule : sas_seq

// file: dv/sas_slice_tb_top.sv
// self-checking bench for the stack address arithmetic slice
`timescale 1ns/1ns
module sas_slice_tb_top;
   import sas_pkg::*;
   logic mclk, rstn, aEn, rEn, carryInN, stepGateN, addrBusOe, resultBusOe, carryOutN;
   logic [3:0] opSel;
   sas_nib_t offsetInN, addrBusOut, resultBusN, resModel;
   sas_nib_t regs [4];
   int bad_count = 0;
   int samples_checked = 0;
   int cycles = 0;
   sas_seq sas_seq_inst(.mclk(mclk), .opSel(opSel), .offsetInN(offsetInN),
      .carryInN(carryInN), .stepGateN(stepGateN));
   sas_slice sas_slice_inst(.mclk(mclk), .rstn(rstn), .opSel(opSel), .offsetInN(offsetInN),
      .carryInN(carryInN), .stepGateN(stepGateN), .addrDriveEnN(aEn), .resultDriveEnN(rEn),
      .addrBusOut(addrBusOut), .addrBusOe(addrBusOe), .resultBusN(resultBusN),
      .resultBusOe(resultBusOe), .carryOutN(carryOutN));
   // --------------------------------
   // clock and hang guard
   // --------------------------------
   initial
   begin
      mclk = 1'b0;
      forever #50 mclk = ~mclk;
   end
   // whole run is under two hundred cycles, so a wide margin
   always @(posedge mclk)
   begin
      cycles++;
      if (cycles == 600)
      begin
         bad_count++;
         test_done();
      end
   end
   // --------------------------------
   // reference decode
   // --------------------------------
   // index 0 of regs stays zero and stands for no register
   function automatic logic [1:0] srcOf(input logic [3:0] c);
      case (c[3:1])
         3'h0, 3'h1, 3'h2: return 2'h1;
         3'h3: return 2'h2;
         3'h6: return 2'h3;
         default: return 2'h0;
      endcase
   endfunction : srcOf
   function automatic logic [1:0] dstOf(input logic [3:0] c);
      case (c)
         4'h0, 4'h1, 4'hb: return 2'h1;
         4'h2, 4'h3, 4'h6, 4'h7, 4'hf: return 2'h2;
         4'h4, 4'h5, 4'h8, 4'h9, 4'hd: return 2'h3;
         default: return 2'h0;
      endcase
   endfunction : dstOf
   function automatic logic [1:0] showOf(input logic [3:0] c);
      case (c)
         4'h0, 4'h2, 4'h4, 4'ha: return 2'h1;
         4'h6, 4'he: return 2'h2;
         default: return 2'h3;
      endcase
   endfunction : showOf
   // --------------------------------
   // shared tasks
   // --------------------------------
   task automatic check(input logic [3:0] got, input logic [3:0] exp, input string what);
      samples_checked++;
      if (got !== exp)
      begin
         bad_count++;
         $display("MISMATCH at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask : check
   // one microcycle; outputs are registered so they are judged after the edge
   task automatic op(input logic [3:0] c, input sas_nib_t d, input logic ci, input logic g);
      logic [4:0] sum;
      sum = {1'b0, regs[srcOf(c)]} + {1'b0, d} + {4'h0, ci};
      sas_seq_inst.issue(c, d, ci, g);
      aEn = c[1];
      rEn = c[2];
      @(posedge mclk);
      #1;
      check(addrBusOut, c[0] ? sum[3:0] : regs[showOf(c)], "address bus");
      if (c[0])
         check({3'h0, carryOutN}, {3'h0, ~sum[4]}, "carry out");
      if (!g && dstOf(c) != 2'h0)
      begin
         regs[dstOf(c)] = sum[3:0];
         resModel = sum[3:0];
      end
      check(resultBusN, ~resModel, "result bus");
      check({2'h0, addrBusOe, resultBusOe}, {2'h0, aEn, rEn}, "enables");
   endtask : op
   task automatic do_reset();
      @(negedge mclk);
      rstn = 1'b0;
      repeat (4) @(negedge mclk);
      rstn = 1'b1;
      regs = '{default: 4'h0};
      resModel = 4'h0;
      check(addrBusOut, 4'h0, "reset address");
      check(resultBusN, 4'hf, "reset result");
      check({addrBusOe, resultBusOe, carryOutN, 1'b0}, 4'he, "reset flags");
   endtask : do_reset
   // --------------------------------
   // scenarios
   // --------------------------------
   // every code once, then again with the gate shut so no register may move
   task automatic test_codes(input logic g);
      for (int i = 0; i < 16; i++)
         op(4'(i), 4'(i) ^ 4'h5, i[3], g);
      $display("test codes gate %0d done", g);
   endtask : test_codes
   // fetch with increment, displacement into third, carry wrap
   task automatic test_program();
      op(4'h0, 4'h1, 1'b0, 1'b0);
      op(4'h0, 4'h1, 1'b0, 1'b0);
      op(4'h5, 4'h6, 1'b0, 1'b0);
      op(4'hb, 4'hf, 1'b0, 1'b0);
      op(4'h1, 4'h0, 1'b1, 1'b0);
      op(4'ha, 4'h3, 1'b1, 1'b0);
      $display("test program done");
   endtask : test_program
   task automatic test_done();
      $display("checks %0d mismatches %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : test_done
   initial
   begin
      rstn = 1'b0;
      aEn = 1'b1;
      rEn = 1'b1;
      do_reset();
      test_codes(1'b0);
      test_codes(1'b1);
      test_program();
      do_reset();
      test_program();
      test_done();
   end
endmodule : sas_slice_tb_top
